// >>> design/spim_consts.svh
// Constants for the delayed-phase serial master
`ifndef SPIM_CONSTS_SVH
`define SPIM_CONSTS_SVH
`define SPIM_DIV_W 7
`define SPIM_PER_W 8
`define SPIM_DATA_W 16
`define SPIM_DIV_FLOOR 7'h03
`define SPIM_PERIOD_FLOOR 8'h04
`define SPIM_PERIOD_MAX_EVEN 8'h80
`define SPIM_PERIOD_MIN_ODD 8'h05
`define SPIM_PERIOD_MAX_ODD 8'h7F
`define SPIM_DIV_ODD_MIN 7'h04
`endif

// >>> design/spim_pkg.sv
// Types for the delayed-phase serial master
package spim_pkg;
  typedef enum logic [4:0] {
    SPIM_IDLE  = 5'b00001,
    SPIM_SETUP = 5'b00010,
    SPIM_LEAD  = 5'b00100,
    SPIM_TRAIL = 5'b01000,
    SPIM_HOLD  = 5'b10000
  } spim_state_t;
endpackage : spim_pkg

// >>> design/spim_master.sv
// Delayed-phase serial master: clock generation, framing and shifting
`timescale 1ns/1ps
`include "spim_consts.svh"

// Overview of operation
// - The frame select goes active with the first bit and stays active until the frame ends, going high for a cycle between chained frames.
// - With divisor plus one even, or divisor 0 or 2, the clock period lies in 4 to 128 cycles.
// - With divisor plus one odd and divisor above 3, the clock period lies in 5 to 127 cycles.
// - For an odd period the active half is half a cycle short and the idle half half long.
// - The polarity input chooses the idle level and so which edge launches and samples.
// - Transfers start only when both the master select and the clock phase inputs are set.
module spim_master
  import spim_pkg::*;
#(
  parameter int DATA_W = `SPIM_DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic master_mode_i,
  input wire logic clock_phase_i,
  input wire logic clock_polarity_i,
  input wire logic [`SPIM_DIV_W-1:0] baud_divisor_i,
  input wire logic start_i,
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic master_in_data_line_i,
  output logic serial_clock_line_o,
  output logic master_out_data_line_o,
  output logic slave_select_frame_n_o,
  output logic [DATA_W-1:0] rx_data_o,
  output logic busy_o,
  output logic done_o
);

  localparam int BIT_W = $clog2(DATA_W + 1);

  function automatic logic [`SPIM_PER_W-1:0] period_of(input logic [`SPIM_DIV_W-1:0] div);
    if (div < `SPIM_DIV_FLOOR) begin
      period_of = `SPIM_PERIOD_FLOOR;
    end else begin
      period_of = {1'b0, div} + 8'h01;
    end
  endfunction : period_of

  spim_state_t state_r, state_nxt;
  logic [`SPIM_PER_W-1:0] period_r, period_nxt;
  logic [`SPIM_PER_W-1:0] cnt_r, cnt_nxt;
  logic [BIT_W-1:0] bits_r, bits_nxt;
  logic [DATA_W-1:0] tx_sh_r, tx_sh_nxt;
  logic [DATA_W-1:0] rx_sh_r, rx_sh_nxt;
  logic [DATA_W-1:0] rx_data_r, rx_data_nxt;
  logic sclk_r, sclk_nxt;
  logic mosi_r, mosi_nxt;
  logic ssel_n_r, ssel_n_nxt;
  logic done_r, done_nxt;
  logic pol_r, pol_nxt;
  logic [`SPIM_PER_W-1:0] lead_len;
  logic [`SPIM_PER_W-1:0] trail_len;
  logic [`SPIM_PER_W-1:0] start_per;

  // Period for a new frame, taken from the divisor at the start request
  assign start_per = period_of(baud_divisor_i);

  // Odd periods give the spare cycle to the idle half
  assign lead_len = {1'b0, period_r[`SPIM_PER_W-1:1]};
  assign trail_len = period_r - lead_len;

  always_comb begin
    state_nxt = state_r;
    period_nxt = period_r;
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    tx_sh_nxt = tx_sh_r;
    rx_sh_nxt = rx_sh_r;
    rx_data_nxt = rx_data_r;
    sclk_nxt = sclk_r;
    mosi_nxt = mosi_r;
    ssel_n_nxt = ssel_n_r;
    done_nxt = 1'b0;
    pol_nxt = pol_r;
    case (state_r)
      SPIM_IDLE: begin
        // Polarity may only move while idle, never mid-frame
        pol_nxt = clock_polarity_i;
        sclk_nxt = clock_polarity_i;
        ssel_n_nxt = 1'b1;
        if (start_i && master_mode_i && clock_phase_i) begin
          period_nxt = start_per;
          tx_sh_nxt = {tx_data_i[DATA_W-2:0], 1'b0};
          mosi_nxt = tx_data_i[DATA_W-1];
          bits_nxt = BIT_W'(DATA_W);
          ssel_n_nxt = 1'b0;
          cnt_nxt = {1'b0, start_per[`SPIM_PER_W-1:1]} - 8'h01;
          state_nxt = SPIM_SETUP;
        end
      end
      SPIM_SETUP: begin
        // First bit stands half a period ahead of the first edge
        if (cnt_r == 8'h00) begin
          sclk_nxt = ~pol_r;
          rx_sh_nxt = {rx_sh_r[DATA_W-2:0], master_in_data_line_i};
          cnt_nxt = lead_len - 8'h01;
          state_nxt = SPIM_LEAD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      SPIM_LEAD: begin
        if (cnt_r == 8'h00) begin
          sclk_nxt = pol_r;
          bits_nxt = bits_r - BIT_W'(1);
          if (bits_r != BIT_W'(1)) begin
            mosi_nxt = tx_sh_r[DATA_W-1];
            tx_sh_nxt = {tx_sh_r[DATA_W-2:0], 1'b0};
          end
          cnt_nxt = trail_len - 8'h01;
          state_nxt = SPIM_TRAIL;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      SPIM_TRAIL: begin
        if (cnt_r == 8'h00) begin
          if (bits_r == '0) begin
            cnt_nxt = lead_len - 8'h01;
            state_nxt = SPIM_HOLD;
          end else begin
            sclk_nxt = ~pol_r;
            rx_sh_nxt = {rx_sh_r[DATA_W-2:0], master_in_data_line_i};
            cnt_nxt = lead_len - 8'h01;
            state_nxt = SPIM_LEAD;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      SPIM_HOLD: begin
        // Select held through a trailing gap after the last edge
        if (cnt_r == 8'h00) begin
          ssel_n_nxt = 1'b1;
          rx_data_nxt = rx_sh_r;
          done_nxt = 1'b1;
          state_nxt = SPIM_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        state_nxt = SPIM_IDLE;
        ssel_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r <= SPIM_IDLE;
      period_r <= `SPIM_PERIOD_FLOOR;
      cnt_r <= 8'h00;
      bits_r <= '0;
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      rx_data_r <= '0;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      ssel_n_r <= 1'b1;
      done_r <= 1'b0;
      pol_r <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      period_r <= period_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_data_r <= rx_data_nxt;
      sclk_r <= sclk_nxt;
      mosi_r <= mosi_nxt;
      ssel_n_r <= ssel_n_nxt;
      done_r <= done_nxt;
      pol_r <= pol_nxt;
    end
  end

  assign serial_clock_line_o = sclk_r;
  assign master_out_data_line_o = mosi_r;
  assign slave_select_frame_n_o = ssel_n_r;
  assign rx_data_o = rx_data_r;
  assign busy_o = (state_r != SPIM_IDLE);
  assign done_o = done_r;

  // Helper counters: cycles since the last leading edge and in the active half
  logic [`SPIM_PER_W-1:0] per_cnt_r;
  logic [`SPIM_PER_W-1:0] act_cnt_r;
  logic seen_r;
  logic lead_edge;
  logic trail_edge;
  // Idle polarity moves are not clock edges of a frame
  assign lead_edge = clk_en_i && (sclk_nxt != sclk_r) && (sclk_nxt == ~pol_r) &&
                     (state_r != SPIM_IDLE);
  assign trail_edge = clk_en_i && (sclk_nxt != sclk_r) && (sclk_nxt == pol_r) &&
                      (state_r != SPIM_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      per_cnt_r <= 8'h00;
      act_cnt_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (clk_en_i) begin
      per_cnt_r <= lead_edge ? 8'h01 : per_cnt_r + 8'h01;
      act_cnt_r <= lead_edge ? 8'h01 : act_cnt_r + 8'h01;
      seen_r <= (state_r == SPIM_IDLE) ? 1'b0 : (seen_r | lead_edge);
    end
  end

  AST_SSEL_FRAME: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state_r inside {SPIM_SETUP, SPIM_LEAD, SPIM_TRAIL, SPIM_HOLD}) |-> !slave_select_frame_n_o)
    else $error("select not active during frame");

  AST_SSEL_BEFORE_EDGE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    lead_edge |-> !ssel_n_r ##1 !slave_select_frame_n_o)
    else $error("clock edge without active select");

  AST_PERIOD_EVEN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (busy_o && !period_r[0]) |-> (period_r >= `SPIM_PERIOD_FLOOR &&
     period_r <= `SPIM_PERIOD_MAX_EVEN))
    else $error("even period out of range");

  AST_PERIOD_ODD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (busy_o && period_r[0]) |-> (period_r >= `SPIM_PERIOD_MIN_ODD &&
     period_r <= `SPIM_PERIOD_MAX_ODD))
    else $error("odd period out of range");

  AST_ACTIVE_HALF: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    trail_edge |-> (act_cnt_r == {1'b0, period_r[`SPIM_PER_W-1:1]}))
    else $error("active half length wrong");

  AST_LEAD_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (lead_edge && busy_o) |=> (serial_clock_line_o != pol_r))
    else $error("leading edge goes to wrong level");

  AST_MODE_GATE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (clk_en_i && state_r == SPIM_IDLE && !(master_mode_i && clock_phase_i)) |=>
    state_r == SPIM_IDLE)
    else $error("transfer started outside delayed-phase master mode");

  AST_PERIOD_LEN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (lead_edge && seen_r) |-> (per_cnt_r == period_r))
    else $error("clock period differs from divisor setting");

endmodule : spim_master

// >>> testbench/spim_slave_model.sv
// Behavioural serial slave facing the master
`timescale 1ns/1ps
module spim_slave_model (
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  input wire logic pol_i,
  input wire logic [15:0] word_i,
  output logic miso_o,
  output logic [15:0] rx_o
);
  logic [15:0] sh_r = 16'h0000;
  initial miso_o = 1'b0;
  initial rx_o = 16'h0000;
  always @(negedge sel_n_i) begin
    sh_r = word_i;
    miso_o = sh_r[15];
  end
  always @(sclk_i) begin
    if (!sel_n_i && sclk_i !== pol_i) begin
      rx_o = {rx_o[14:0], mosi_i};
    end else if (!sel_n_i) begin
      sh_r = sh_r << 1;
      miso_o = sh_r[15];
    end
  end
  // No pull on the line: invert so a stale bit never passes
  always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule : spim_slave_model

// >>> testbench/tb_top.sv
// Self-checking bench for the delayed-phase serial master
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, start = 1'b0, pol = 1'b0, ph = 1'b1, ms = 1'b1;
  logic [6:0] div = 7'h03;
  logic [15:0] tx = 16'h0000, sw = 16'h0000, rxd, s_rx;
  logic sclk, mosi, miso, sel_n, busy, done, prev;
  int n_fail = 0, total_checks = 0, cyc = 0, run = 0, act = 0, idl = 0, leads = 0;
  initial forever #5 clk = ~clk;
  spim_master spim_master_i (.clk_sys_i(clk), .resetn_i(rstn), .clk_en_i(1'b1),
    .master_mode_i(ms), .clock_phase_i(ph), .clock_polarity_i(pol), .baud_divisor_i(div),
    .start_i(start), .tx_data_i(tx), .master_in_data_line_i(miso),
    .serial_clock_line_o(sclk), .master_out_data_line_o(mosi),
    .slave_select_frame_n_o(sel_n), .rx_data_o(rxd), .busy_o(busy), .done_o(done));
  spim_slave_model spim_slave_model_i (.sclk_i(sclk), .sel_n_i(sel_n), .mosi_i(mosi),
    .pol_i(pol), .word_i(sw), .miso_o(miso), .rx_o(s_rx));
  // Run lengths of each clock level while the frame is selected
  always @(posedge clk) begin
    if (sel_n === 1'b0 && sclk !== prev) begin
      if (prev === pol) idl = run;
      else act = run;
      if (sclk !== pol) leads++;
      run = 1;
    end else run = (sel_n === 1'b0) ? run + 1 : 0;
    prev = sclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // Chained frames raise the next start in the done cycle
  task automatic frame(input logic [6:0] dv, input logic pl, input logic [15:0] tw,
                       input logic [15:0] swd, input bit chain);
    int n, p;
    p = (dv >= 3) ? dv + 1 : 4;
    div = dv;
    tx = tw;
    sw = swd;
    leads = 0;
    n = 0;
    if (start !== 1'b1) begin
      pol = pl;
      repeat (3) @(posedge clk);
      #1 start = 1'b1;
    end
    @(posedge clk);
    #1 start = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
    if (chain) start = 1'b1;
    chk("frame_len", p / 2 + 16 * p + p / 2, n);
    chk("active_half", p / 2, act);
    chk("period", p, act + idl);
    chk("edges_in_frame", 16, leads);
    chk("rx_data", swd, rxd);
    chk("slave_rx", tw, s_rx);
  endtask : frame
  logic [6:0] dvs [7] = '{7'h03, 7'h04, 7'h00, 7'h02, 7'h7E, 7'h7F, 7'h05};
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ph = k[0];
      ms = ~k[0];
      start = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("busy_refused", 0, busy);
      chk("select_refused", 1, sel_n);
      start = 1'b0;
    end
    ph = 1'b1;
    ms = 1'b1;
    for (int i = 0; i < 7; i++) begin
      frame(dvs[i], i[0], 16'(16'hA5C3 ^ (16'h1111 * i)), 16'(16'h3C5A + (16'h0F0F * i)),
            i == 5);
    end
    complete_run();
  end
endmodule : tb_top
